/* design/mode_ctrl.sv */
// Operating-mode control of a three-axis accelerometer: power states,
// subsystem enables, register retention and output sample registers.
// Assumes supply monitor, auto-sleep logic and converters sit outside.
//
// What this block does
// - Supply below power-down level: all off, bus inhibited
// - Active bit clear: standby, digital only, bus on
// - Active bit set: digital and analog run
// - Active to standby keeps every register
// - Standby to active resets designated registers
// - Sleep and wake exist only while active
// - Counts per g: 256, 128, 64 by range
// - Two's complement samples from address 0x00
// - Self-test output is acceleration plus stimulus
// - First valid sample within 2/ODR plus 1 ms
`timescale 1ns/100ps
module mode_ctrl #(
    parameter int unsigned ACCEL_W          = mode_ctrl_pkg::ACCEL_W,
    parameter int unsigned TIMER_W          = mode_ctrl_pkg::TIMER_W,
    parameter int unsigned TON_EXTRA_CYCLES = mode_ctrl_pkg::TON_EXTRA_CYCLES
) (
    input  wire logic                      clk,
    input  wire logic                      rst_b,
    input  wire logic                      supply_ok,
    input  wire logic                      active_bit,
    input  wire logic                      sleep_req,
    input  wire logic                      wake_evt,
    input  wire logic [1:0]                range_sel,
    input  wire logic                      self_test,
    input  wire logic [TIMER_W-2:0]        odr_period,
    input  wire logic                      sample_strobe,
    input  wire logic signed [ACCEL_W-1:0] accel_x,
    input  wire logic signed [ACCEL_W-1:0] accel_y,
    input  wire logic signed [ACCEL_W-1:0] accel_z,
    input  wire logic signed [ACCEL_W-1:0] stim_x,
    input  wire logic signed [ACCEL_W-1:0] stim_y,
    input  wire logic signed [ACCEL_W-1:0] stim_z,
    input  wire logic [7:0]                rd_addr,
    output logic [7:0]                     rd_data,
    output logic                           i2c_en,
    output logic                           digital_en,
    output logic                           analog_en,
    output logic                           clocks_en,
    output logic                           sleeping,
    output logic                           reg_clear,
    output logic                           data_valid,
    output logic [9:0]                     out_x,
    output logic [9:0]                     out_y,
    output logic [9:0]                     out_z
);
    mode_ctrl_pkg::mode_e mode;
    mode_ctrl_pkg::mode_e next_mode;
    logic                 active_now;
    logic                 entering;
    logic [TIMER_W-1:0]   ton_cnt;
    logic [TIMER_W-1:0]   ton_limit;
    logic                 ton_done;
    logic                 capture;
    logic [9:0]           scaled_x;
    logic [9:0]           scaled_y;
    logic [9:0]           scaled_z;

    sense_cfg_if cfg ();
    assign cfg.range     = range_sel;
    assign cfg.self_test = self_test;

    axis_scale #(.ACCEL_W(ACCEL_W)) u_scale_x (
        .cfg    (cfg),
        .accel  (accel_x),
        .stim   (stim_x),
        .counts (scaled_x)
    );
    axis_scale #(.ACCEL_W(ACCEL_W)) u_scale_y (
        .cfg    (cfg),
        .accel  (accel_y),
        .stim   (stim_y),
        .counts (scaled_y)
    );
    axis_scale #(.ACCEL_W(ACCEL_W)) u_scale_z (
        .cfg    (cfg),
        .accel  (accel_z),
        .stim   (stim_z),
        .counts (scaled_z)
    );

    always_comb begin
        next_mode = mode;
        if (!supply_ok) begin
            next_mode = mode_ctrl_pkg::MODE_OFF;
        end else begin
            unique case (mode)
                mode_ctrl_pkg::MODE_OFF,
                mode_ctrl_pkg::MODE_STANDBY: begin
                    next_mode = active_bit ? mode_ctrl_pkg::MODE_WAKE
                                           : mode_ctrl_pkg::MODE_STANDBY;
                end
                mode_ctrl_pkg::MODE_WAKE: begin
                    if (!active_bit) begin
                        next_mode = mode_ctrl_pkg::MODE_STANDBY;
                    end else if (sleep_req) begin
                        next_mode = mode_ctrl_pkg::MODE_SLEEP;
                    end
                end
                mode_ctrl_pkg::MODE_SLEEP: begin
                    if (!active_bit) begin
                        next_mode = mode_ctrl_pkg::MODE_STANDBY;
                    end else if (wake_evt) begin
                        next_mode = mode_ctrl_pkg::MODE_WAKE;
                    end
                end
                default: next_mode = mode_ctrl_pkg::MODE_OFF;
            endcase
        end
    end

    // Mode moves on the active bit, supply, sleep_req and wake_evt; host writes the active bit
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            mode <= mode_ctrl_pkg::MODE_OFF;
        end else begin
            mode <= next_mode;
        end
    end

    // Enables follow next_mode so they line up with the mode register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            i2c_en     <= 1'b0;
            digital_en <= 1'b0;
            analog_en  <= 1'b0;
            clocks_en  <= 1'b0;
            sleeping   <= 1'b0;
        end else begin
            i2c_en     <= next_mode != mode_ctrl_pkg::MODE_OFF;
            digital_en <= next_mode != mode_ctrl_pkg::MODE_OFF;
            analog_en  <= next_mode == mode_ctrl_pkg::MODE_WAKE ||
                          next_mode == mode_ctrl_pkg::MODE_SLEEP;
            clocks_en  <= next_mode == mode_ctrl_pkg::MODE_WAKE ||
                          next_mode == mode_ctrl_pkg::MODE_SLEEP;
            sleeping   <= next_mode == mode_ctrl_pkg::MODE_SLEEP;
        end
    end

    assign active_now = mode == mode_ctrl_pkg::MODE_WAKE ||
                        mode == mode_ctrl_pkg::MODE_SLEEP;
    assign entering   = !active_now &&
                        (next_mode == mode_ctrl_pkg::MODE_WAKE);

    // Turn-on timer; counting stops at the limit so it cannot wrap
    assign ton_limit = TIMER_W'(mode_ctrl_pkg::TON_ODR_PERIODS) *
                       TIMER_W'(odr_period) + TIMER_W'(TON_EXTRA_CYCLES);
    assign ton_done  = active_now && ton_cnt >= ton_limit;
    // No capture on the edge that leaves active, so standby keeps all
    assign capture   = active_now && active_bit && supply_ok &&
                       (ton_done && !data_valid ||
                        data_valid && sample_strobe);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ton_cnt <= '0;
        end else if (entering) begin
            ton_cnt <= '0;
        end else if (active_now && ton_cnt < ton_limit) begin
            ton_cnt <= ton_cnt + TIMER_W'(1);
        end
    end

    // Samples and valid flag are the registers cleared on turn-on;
    // in standby nothing is captured, so contents stand unchanged
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            out_x      <= mode_ctrl_pkg::SAMPLE_RESET;
            out_y      <= mode_ctrl_pkg::SAMPLE_RESET;
            out_z      <= mode_ctrl_pkg::SAMPLE_RESET;
            data_valid <= 1'b0;
        end else if (entering) begin
            out_x      <= mode_ctrl_pkg::SAMPLE_RESET;
            out_y      <= mode_ctrl_pkg::SAMPLE_RESET;
            out_z      <= mode_ctrl_pkg::SAMPLE_RESET;
            data_valid <= 1'b0;
        end else if (capture) begin
            out_x      <= scaled_x;
            out_y      <= scaled_y;
            out_z      <= scaled_z;
            data_valid <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            reg_clear <= 1'b0;
        end else begin
            reg_clear <= entering;
        end
    end

    // Left-justified 10-bit samples: upper eight bits, then two
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rd_data <= 8'h00;
        end else begin
            unique case (rd_addr)
                mode_ctrl_pkg::OUT_X_MSB_ADDR: rd_data <= out_x[9:2];
                mode_ctrl_pkg::OUT_X_LSB_ADDR: rd_data <= {out_x[1:0], 6'h00};
                mode_ctrl_pkg::OUT_Y_MSB_ADDR: rd_data <= out_y[9:2];
                mode_ctrl_pkg::OUT_Y_LSB_ADDR: rd_data <= {out_y[1:0], 6'h00};
                mode_ctrl_pkg::OUT_Z_MSB_ADDR: rd_data <= out_z[9:2];
                mode_ctrl_pkg::OUT_Z_LSB_ADDR: rd_data <= {out_z[1:0], 6'h00};
                default:                       rd_data <= 8'h00;
            endcase
        end
    end

    property p_off;
        @(posedge clk) disable iff (!rst_b)
        !supply_ok |=> mode == mode_ctrl_pkg::MODE_OFF && !i2c_en &&
                       !digital_en && !analog_en;
    endproperty
    a_off: assert property (p_off) else $error("off not entered");

    property p_standby;
        @(posedge clk) disable iff (!rst_b)
        mode == mode_ctrl_pkg::MODE_STANDBY |->
            digital_en && i2c_en && !analog_en && !clocks_en;
    endproperty
    a_standby: assert property (p_standby) else $error("standby");

    property p_active;
        @(posedge clk) disable iff (!rst_b)
        supply_ok && active_bit |=>
            active_now && analog_en && clocks_en && digital_en && i2c_en;
    endproperty
    a_active: assert property (p_active) else $error("active enables");

    property p_retain;
        @(posedge clk) disable iff (!rst_b)
        active_now ##1 mode == mode_ctrl_pkg::MODE_STANDBY |->
            $stable(out_x) && $stable(out_y) && $stable(out_z);
    endproperty
    a_retain: assert property (p_retain) else $error("samples lost");

    property p_clear;
        @(posedge clk) disable iff (!rst_b)
        mode == mode_ctrl_pkg::MODE_STANDBY && active_bit && supply_ok |=>
            reg_clear && out_x == mode_ctrl_pkg::SAMPLE_RESET && !data_valid;
    endproperty
    a_clear: assert property (p_clear) else $error("no clear");

    property p_sub;
        @(posedge clk) disable iff (!rst_b)
        mode == mode_ctrl_pkg::MODE_SLEEP || sleeping |-> $past(active_bit);
    endproperty
    a_sub: assert property (p_sub) else $error("sleep without active");

    property p_scale;
        @(posedge clk) disable iff (!rst_b)
        capture && !self_test && range_sel == mode_ctrl_pkg::RANGE_4G &&
        accel_x < 16'sd4096 && accel_x > -16'sd4096 |=>
            out_x == 10'($past(accel_x) >>> 3);
    endproperty
    a_scale: assert property (p_scale) else $error("4g scale wrong");

    property p_selftest;
        @(posedge clk) disable iff (!rst_b)
        capture && self_test && range_sel == mode_ctrl_pkg::RANGE_2G &&
        accel_x <= 16'sd1024 && accel_x >= -16'sd1024 &&
        stim_x < 16'sd1024 && stim_x > -16'sd1024 |=>
            out_x == 10'(($past(accel_x) + $past(stim_x)) >>> 2);
    endproperty
    a_selftest: assert property (p_selftest) else $error("self-test");

    property p_readout;
        @(posedge clk) disable iff (!rst_b)
        rd_addr == mode_ctrl_pkg::OUT_X_MSB_ADDR |=>
            rd_data == $past(out_x[9:2]);
    endproperty
    a_readout: assert property (p_readout) else $error("read at zero");

    property p_turn_on;
        @(posedge clk) disable iff (!rst_b)
        active_now && ton_cnt == ton_limit && $stable(ton_limit) |=>
            data_valid || !active_now;
    endproperty
    a_turn_on: assert property (p_turn_on) else $error("late sample");
endmodule

/* inc/mode_ctrl_pkg.sv */
// Constants and types shared by the operating-mode control and its
// axis scalers. Assumes a single 100 MHz clock domain.
package mode_ctrl_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;

    // Fixed part of the standby-to-active turn-on delay
    localparam int unsigned TON_EXTRA_MS     = 1;
    localparam int unsigned TON_EXTRA_CYCLES =
        (TON_EXTRA_MS * 1000000) / CLK_PERIOD_NS;
    localparam int unsigned TON_ODR_PERIODS  = 2;

    localparam int unsigned SAMPLE_W = 10;
    localparam int unsigned ACCEL_W  = 16;
    localparam int unsigned TIMER_W  = 28;

    // Full-scale range codes and right shifts from 1/1024 g input units
    typedef logic [1:0] range_t;
    localparam range_t RANGE_2G = 2'h0;
    localparam range_t RANGE_4G = 2'h1;
    localparam range_t RANGE_8G = 2'h2;
    localparam int unsigned SHIFT_2G = 2;
    localparam int unsigned SHIFT_4G = 3;
    localparam int unsigned SHIFT_8G = 4;

    // Output sample registers, MSB/LSB pairs from address zero
    localparam logic [7:0] OUT_X_MSB_ADDR = 8'h00;
    localparam logic [7:0] OUT_X_LSB_ADDR = 8'h01;
    localparam logic [7:0] OUT_Y_MSB_ADDR = 8'h02;
    localparam logic [7:0] OUT_Y_LSB_ADDR = 8'h03;
    localparam logic [7:0] OUT_Z_MSB_ADDR = 8'h04;
    localparam logic [7:0] OUT_Z_LSB_ADDR = 8'h05;

    localparam logic [SAMPLE_W-1:0] SAMPLE_RESET = 10'h000;

    typedef enum logic [3:0] {
        MODE_OFF     = 4'h1,
        MODE_STANDBY = 4'h2,
        MODE_WAKE    = 4'h4,
        MODE_SLEEP   = 4'h8
    } mode_e;

endpackage

/* inc/sense_cfg_if.sv */
// Scaling configuration passed from the mode control to its scalers.
// Assumes the package is compiled first.
`timescale 1ns/100ps
interface sense_cfg_if;
    mode_ctrl_pkg::range_t range;
    logic                  self_test;

    modport src (output range, output self_test);
    modport dst (input range, input self_test);
endinterface

/* design/axis_scale.sv */
// One axis: adds self-test stimulus, scales by range, saturates.
// Assumes inputs in 1/1024 g units; purely combinational.
`timescale 1ns/100ps
module axis_scale #(
    parameter int unsigned ACCEL_W  = mode_ctrl_pkg::ACCEL_W,
    parameter int unsigned SAMPLE_W = mode_ctrl_pkg::SAMPLE_W
) (
    sense_cfg_if.dst                    cfg,
    input  wire logic signed [ACCEL_W-1:0]  accel,
    input  wire logic signed [ACCEL_W-1:0]  stim,
    output logic signed      [SAMPLE_W-1:0] counts
);
    localparam logic signed [ACCEL_W:0] MAX_C = (ACCEL_W+1)'(
        (1 << (SAMPLE_W - 1)) - 1);
    localparam logic signed [ACCEL_W:0] MIN_C = -MAX_C - 1;

    logic signed [ACCEL_W:0] sum;
    logic signed [ACCEL_W:0] scaled;

    always_comb begin
        // Stimulus added before scaling, so its shift tracks sensitivity
        sum = cfg.self_test ? (ACCEL_W+1)'(accel) + (ACCEL_W+1)'(stim)
                            : (ACCEL_W+1)'(accel);
        unique case (cfg.range)
            mode_ctrl_pkg::RANGE_2G: scaled = sum >>> mode_ctrl_pkg::SHIFT_2G;
            mode_ctrl_pkg::RANGE_4G: scaled = sum >>> mode_ctrl_pkg::SHIFT_4G;
            default:                 scaled = sum >>> mode_ctrl_pkg::SHIFT_8G;
        endcase
        if (scaled > MAX_C) begin
            counts = SAMPLE_W'(MAX_C);
        end else if (scaled < MIN_C) begin
            counts = SAMPLE_W'(MIN_C);
        end else begin
            counts = SAMPLE_W'(scaled);
        end
    end
endmodule

/* tb/host_model.sv */
// Host side of the mode control: owns the active bit and output reads.
// Assumes one clock shared with the device; the bench calls its tasks.
`timescale 1ns/100ps
module host_model (
    input  wire logic       clk,
    output logic            active_bit,
    output logic [7:0]      rd_addr,
    input  wire logic [7:0] rd_data
);
    initial begin
        active_bit = 1'b0;
        rd_addr    = 8'h00;
    end

    // Host mode changes only ever go through the active bit; sleep and wake come from the bench
    task automatic set_active(input logic v);
        @(posedge clk);
        active_bit <= v;
        @(posedge clk);
        #1;
    endtask

    // Read data is registered, so it is taken one edge after the address
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        rd_addr <= a;
        @(posedge clk);
        #1;
        d = rd_data;
    endtask
endmodule

/* tb/mode_ctrl_tb.sv */
// Self-checking bench for the operating-mode control.
// Assumes package, interface, design and host model compiled first.
`timescale 1ns/100ps
module mode_ctrl_tb;
    localparam int unsigned EXTRA = 20;
    localparam int unsigned ODR   = 5;
    localparam int unsigned TON   = 2 * ODR + EXTRA;

    logic                               clk;
    logic                               rst_b;
    logic                               supply_ok;
    logic                               active_bit;
    logic                               sleep_req;
    logic                               wake_evt;
    logic [1:0]                         range_sel;
    logic                               self_test;
    logic [mode_ctrl_pkg::TIMER_W-2:0]  odr_period;
    logic                               sample_strobe;
    logic signed [15:0]                 accel_x;
    logic signed [15:0]                 accel_y;
    logic signed [15:0]                 accel_z;
    logic signed [15:0]                 stim_x;
    logic signed [15:0]                 stim_y;
    logic signed [15:0]                 stim_z;
    logic [7:0]                         rd_addr;
    logic [7:0]                         rd_data;
    logic                               i2c_en;
    logic                               digital_en;
    logic                               analog_en;
    logic                               clocks_en;
    logic                               sleeping;
    logic                               reg_clear;
    logic                               data_valid;
    logic [9:0]                         out_x;
    logic [9:0]                         out_y;
    logic [9:0]                         out_z;
    int                                 err_count;
    int                                 n_checks;
    int                                 cycles = 0;

    mode_ctrl #(.TON_EXTRA_CYCLES(EXTRA)) i_dut (
        .clk(clk), .rst_b(rst_b), .supply_ok(supply_ok),
        .active_bit(active_bit), .sleep_req(sleep_req),
        .wake_evt(wake_evt), .range_sel(range_sel),
        .self_test(self_test), .odr_period(odr_period),
        .sample_strobe(sample_strobe), .accel_x(accel_x),
        .accel_y(accel_y), .accel_z(accel_z), .stim_x(stim_x),
        .stim_y(stim_y), .stim_z(stim_z), .rd_addr(rd_addr),
        .rd_data(rd_data), .i2c_en(i2c_en), .digital_en(digital_en),
        .analog_en(analog_en), .clocks_en(clocks_en),
        .sleeping(sleeping), .reg_clear(reg_clear),
        .data_valid(data_valid), .out_x(out_x), .out_y(out_y),
        .out_z(out_z)
    );

    host_model i_host (
        .clk(clk), .active_bit(active_bit), .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp,
                         input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Order: i2c, digital, analog, clocks, sleeping
    function automatic logic [15:0] enables();
        return {11'h000, i2c_en, digital_en, analog_en, clocks_en, sleeping};
    endfunction

    task automatic strobe();
        @(posedge clk);
        sample_strobe <= 1'b1;
        @(posedge clk);
        sample_strobe <= 1'b0;
        tick(1);
    endtask

    task automatic t_off_standby();
        tick(1);
        check(enables(), 16'h0000, "off enables");
        @(posedge clk);
        supply_ok <= 1'b1;
        sleep_req <= 1'b1;
        tick(2);
        check(enables(), 16'h0018, "standby enables");
        @(posedge clk);
        sleep_req <= 1'b0;
    endtask

    task automatic t_turn_on(input logic [9:0] old_x);
        int n;
        check(out_x, 16'(old_x), "held in standby");
        i_host.set_active(1'b1);
        check(enables(), 16'h001e, "active enables");
        check(reg_clear, 16'h0001, "clear pulse");
        check(out_x, 16'h0000, "cleared sample");
        check(data_valid, 16'h0000, "valid cleared");
        n = 1;
        while (data_valid !== 1'b1 && n < TON + 8) begin
            tick(1);
            n++;
        end
        check(16'(n <= TON + 2), 16'h0001, "turn-on delay");
        check(out_x, 16'h0100, "x at 1g 2g");
        check(out_y, 16'h037f, "y negative");
        check(out_z, 16'h0300, "z negative");
    endtask

    task automatic t_read();
        logic [7:0] d;
        logic [7:0] addrs [7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05,
                                  8'h06};
        logic [7:0] exps [7]  = '{8'h40, 8'h00, 8'hdf, 8'hc0, 8'hc0, 8'h00,
                                  8'h00};
        for (int i = 0; i < 7; i++) begin
            i_host.read_reg(addrs[i], d);
            check(d, exps[i], "read data");
        end
    endtask

    task automatic t_ranges();
        for (int r = 0; r < 4; r++) begin
            @(posedge clk);
            range_sel <= 2'(r);
            strobe();
            check(out_x, 16'h0100 >> (r == 3 ? 2 : r), "range x");
        end
        @(posedge clk);
        range_sel <= 2'h0;
        self_test <= 1'b1;
        strobe();
        check(out_x, 16'h0140, "self-test sum");
        @(posedge clk);
        self_test <= 1'b0;
        strobe();
    endtask

    task automatic t_sleep_standby_off();
        @(posedge clk);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        tick(1);
        check(enables(), 16'h001f, "sleep entered");
        @(posedge clk);
        wake_evt <= 1'b1;
        @(posedge clk);
        wake_evt <= 1'b0;
        tick(1);
        check(enables(), 16'h001e, "woken");
        @(posedge clk);
        sleep_req <= 1'b1;
        @(posedge clk);
        sleep_req <= 1'b0;
        tick(1);
        check(enables(), 16'h001f, "asleep again");
        i_host.set_active(1'b0);
        check(enables(), 16'h0018, "back to standby");
        check(out_x, 16'h0100, "kept sample");
        check(data_valid, 16'h0001, "kept valid");
        t_turn_on(10'h100);
        @(posedge clk);
        supply_ok <= 1'b0;
        tick(1);
        check(enables(), 16'h0000, "supply lost");
    endtask

    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            complete_run();
        end
    end

    initial begin
        err_count = 0;
        n_checks = 0;
        rst_b = 1'b0;
        supply_ok = 1'b0;
        sleep_req = 1'b0;
        wake_evt = 1'b0;
        range_sel = 2'h0;
        self_test = 1'b0;
        odr_period = 27'(ODR);
        sample_strobe = 1'b0;
        accel_x = 16'sh0400;
        accel_y = -16'sd516;
        accel_z = -16'sd1024;
        stim_x = 16'sh0100;
        stim_y = 16'sh0000;
        stim_z = 16'sh0000;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        t_off_standby();
        t_turn_on(10'h000);
        t_read();
        t_ranges();
        t_sleep_standby_off();
        complete_run();
    end
endmodule
